// File: hw/sarc_pkg.sv
/*
 Shared constants, state type and helper functions of the
 simultaneous SAR conversion control.
 Assumes nothing of its surroundings.
*/
package sarc_pkg;
  localparam int DATA_W  = 16;
  localparam int NUM_CH  = 4;
  localparam int RANGE_W = 3;
  localparam int CH_W    = 2;
  localparam int FRAME_W = NUM_CH * DATA_W;
  localparam int ADDR_W  = 8;
  localparam int CNT_W   = 6;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RANGE  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h10;

  localparam int CTRL_LANES_LSB = 0;
  localparam int CTRL_NAP_BIT   = 2;
  localparam int CTRL_PD_BIT    = 3;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_LVDS_BIT  = 2;
  localparam int STAT_NAP_BIT   = 3;
  localparam int STAT_PD_BIT    = 4;
  localparam int STAT_CNT_LSB   = 16;
  localparam int RES_RANGE_LSB  = 16;

  localparam logic [1:0]  LANES_RST   = 2'h0;
  localparam logic [11:0] RANGE_RST   = 12'hfff;
  localparam logic [2:0]  RANGE_OFF   = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] SIGN_FLIP   = 16'h8000;

  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_SETTLE_NS = 40;
  localparam int SETTLE_CYC =
    (BIT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_TRACK, ST_LOAD, ST_SAR, ST_DONE}
    sarc_state_t;

  function automatic logic sarc_is_bipolar(input logic [2:0] rng);
    return (rng == 3'h7) || (rng == 3'h6) ||
           (rng == 3'h3) || (rng == 3'h2);
  endfunction : sarc_is_bipolar

  function automatic logic [15:0] sarc_format(input logic [15:0] raw,
                                              input logic [2:0]  rng);
    if (rng == RANGE_OFF)
      return 16'h0000;
    else if (sarc_is_bipolar(rng))
      return raw ^ SIGN_FLIP;
    else
      return raw;
  endfunction : sarc_format

  function automatic logic [2:0] sarc_range_of(input logic [11:0] cfg,
                                               input int          ch);
    return cfg[ch*RANGE_W +: RANGE_W];
  endfunction : sarc_range_of

  // Returns {found, index} of first enabled channel at or above start
  function automatic logic [2:0] sarc_next_ch(input logic [3:0] mask,
                                              input int         start);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && i >= start)
        r = {1'b1, i[1:0]};
    end
    return r;
  endfunction : sarc_next_ch

  function automatic logic [31:0] sarc_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        r[b*8 +: 8] = data[b*8 +: 8];
    end
    return r;
  endfunction : sarc_merge

  // Lane k carries channels k, k+lanes, ... MSB first
  function automatic logic [63:0] sarc_lane_word(input logic [63:0] pub,
                                                 input int lane,
                                                 input int lanes);
    logic [63:0] w;
    int          pos;
    w   = 64'h0;
    pos = FRAME_W - 1;
    for (int c = 0; c < NUM_CH; c++) begin
      if ((c % lanes) == lane) begin
        w[pos -: DATA_W] = pub[FRAME_W - 1 - c*DATA_W -: DATA_W];
        pos = pos - DATA_W;
      end
    end
    return w;
  endfunction : sarc_lane_word
endpackage : sarc_pkg

// File: hw/sarc_sar_step.sv
/*
 One successive-approximation run on the shared DAC: sixteen
 bit trials from the MSB down, one decision per trial.
 Assumes cmp_above is already synchronised to aclk and the
 settle count covers DAC settling plus the two-flop delay.
*/
`timescale 1ns/10ps

module sarc_sar_step #(
  parameter int SETTLE_CYCLES = sarc_pkg::SETTLE_CYC,
  parameter int DATA_W        = sarc_pkg::DATA_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              start,
  input  wire logic              cmp_above,
  output logic [DATA_W-1:0]      dac_code,
  output logic [DATA_W-1:0]      result,
  output logic                   done
);
  localparam int BIT_W = $clog2(DATA_W);

  logic [DATA_W-1:0] code_ff;
  logic [DATA_W-1:0] result_ff;
  logic [DATA_W-1:0] nxt_code;
  logic [BIT_W-1:0]  bit_ff;
  logic [7:0]        wait_ff;
  logic              run_ff;
  logic              done_ff;

  always_comb begin
    nxt_code = code_ff;
    // Sample below trial level: drop the trial bit
    if (!cmp_above)
      nxt_code[bit_ff] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_ff   <= '0;
      result_ff <= '0;
      bit_ff    <= '0;
      wait_ff   <= 8'h00;
      run_ff    <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        code_ff <= {1'b1, {(DATA_W-1){1'b0}}};
        bit_ff  <= BIT_W'(DATA_W - 1);
        wait_ff <= 8'(SETTLE_CYCLES);
        run_ff  <= 1'b1;
      end else if (run_ff) begin
        if (wait_ff != 8'h00) begin
          wait_ff <= wait_ff - 8'h01;
        end else if (bit_ff == '0) begin
          code_ff   <= nxt_code;
          result_ff <= nxt_code;
          run_ff    <= 1'b0;
          done_ff   <= 1'b1;
        end else begin
          code_ff             <= nxt_code;
          code_ff[bit_ff - 1] <= 1'b1;
          bit_ff              <= bit_ff - 1'b1;
          wait_ff             <= 8'(SETTLE_CYCLES);
        end
      end
    end
  end

  assign dac_code = code_ff;
  assign result   = result_ff;
  assign done     = done_ff;
endmodule : sarc_sar_step

// File: hw/sarc_top.sv
/*
 Top of the simultaneous SAR conversion control: AXI4-Lite
 registers, convert sequencing over one shared DAC, result
 formatting by range code, and the serial result port.
 Assumes an analog core with per-channel sample-and-hold, a
 channel mux, a DAC and one comparator, and a host that clocks
 sck only while cs_n is low.
*/
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps

module sarc_top #(
  parameter int SETTLE_CYCLES = sarc_pkg::SETTLE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        convert_start,
  input  wire logic        cmp_above,
  input  wire logic        lvds_select,
  input  wire logic        sck,
  input  wire logic        cs_n,
  output logic [3:0]       sdo,
  output logic             busy,
  output logic [3:0]       sample_track,
  output logic [1:0]       mux_channel,
  output logic [15:0]      dac_code,
  output logic [2:0]       span_code,
  output logic             nap_active,
  output logic             power_down_active,
  output logic             lvds_active
);
  localparam int NCH = sarc_pkg::NUM_CH;
  localparam int DW  = sarc_pkg::DATA_W;
  localparam int FW  = sarc_pkg::FRAME_W;

  logic [2:0]  cnv_sync_ff;
  logic [1:0]  cmp_sync_ff;
  logic [1:0]  lvds_sync_ff;
  logic        cnv_rise;

  logic [1:0]  lanes_cfg_ff;
  logic        nap_en_ff;
  logic        pd_en_ff;
  logic [11:0] range_cfg_ff;
  logic        done_ff;
  logic [15:0] conv_cnt_ff;
  logic [1:0]  eff_lanes_ff;

  logic        aw_ok_ff;
  logic        w_ok_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [31:0] wr_merged;

  sarc_pkg::sarc_state_t state_ff;
  logic [1:0]  ch_ff;
  logic [11:0] range_cur_ff;
  logic [11:0] pub_range_ff;
  logic [FW-1:0] res_ff;
  logic [FW-1:0] pub_ff;
  logic [3:0]  track_ff;
  logic        sar_start_ff;
  logic        nap_ff;
  logic [3:0]  en_cfg;
  logic [3:0]  en_cur;
  logic [2:0]  nxt_first;
  logic [2:0]  nxt_after;
  logic        sar_done;
  logic [15:0] sar_result;

  logic [1:0]  lanes_s1_ff;
  logic [1:0]  lanes_s2_ff;
  logic [5:0]  bit_cnt_ff;
  logic [3:0]  sdo_ff;
  logic [63:0] lane_words [4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnv_sync_ff  <= 3'h0;
      cmp_sync_ff  <= 2'h0;
      lvds_sync_ff <= 2'h0;
    end else begin
      cnv_sync_ff  <= {cnv_sync_ff[1:0], convert_start};
      cmp_sync_ff  <= {cmp_sync_ff[0], cmp_above};
      lvds_sync_ff <= {lvds_sync_ff[0], lvds_select};
    end
  end

  assign cnv_rise = cnv_sync_ff[1] && !cnv_sync_ff[2];

  // AXI4-Lite write: address and data taken in either order
  assign wr_fire = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign wr_hit  = (waddr_ff == sarc_pkg::OFS_CTRL) ||
                   (waddr_ff == sarc_pkg::OFS_RANGE) ||
                   (waddr_ff == sarc_pkg::OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      waddr_ff  <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= sarc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_ok_ff) begin
        aw_ok_ff <= 1'b1;
        waddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_ok_ff) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? sarc_pkg::RESP_OKAY
                            : sarc_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      sarc_pkg::OFS_CTRL: begin
        rd_mux[1:0] = lanes_cfg_ff;
        rd_mux[sarc_pkg::CTRL_NAP_BIT] = nap_en_ff;
        rd_mux[sarc_pkg::CTRL_PD_BIT]  = pd_en_ff;
      end
      sarc_pkg::OFS_RANGE:  rd_mux[11:0] = range_cfg_ff;
      sarc_pkg::OFS_STATUS: begin
        rd_mux[sarc_pkg::STAT_BUSY_BIT] = busy;
        rd_mux[sarc_pkg::STAT_DONE_BIT] = done_ff;
        rd_mux[sarc_pkg::STAT_LVDS_BIT] = lvds_active;
        rd_mux[sarc_pkg::STAT_NAP_BIT]  = nap_active;
        rd_mux[sarc_pkg::STAT_PD_BIT]   = power_down_active;
        rd_mux[31:16] = conv_cnt_ff;
      end
      default: begin
        rd_hit = 1'b0;
        for (int c = 0; c < NCH; c++) begin
          if (s_axi_araddr[7:2] == 6'(sarc_pkg::OFS_RESULT[7:2] + c)) begin
            rd_hit = 1'b1;
            rd_mux[15:0]  = pub_ff[FW - 1 - c*DW -: DW];
            rd_mux[18:16] = sarc_pkg::sarc_range_of(pub_range_ff, c);
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= sarc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_hit ? sarc_pkg::RESP_OKAY : sarc_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_comb wr_merged = sarc_merge_c();

  // Control and status registers; done set wins over its clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lanes_cfg_ff <= sarc_pkg::LANES_RST;
      nap_en_ff    <= 1'b0;
      pd_en_ff     <= 1'b0;
      range_cfg_ff <= sarc_pkg::RANGE_RST;
      done_ff      <= 1'b0;
      eff_lanes_ff <= sarc_pkg::LANES_RST;
    end else begin
      if (wr_fire && waddr_ff == sarc_pkg::OFS_CTRL) begin
        lanes_cfg_ff <= wr_merged[1:0];
        nap_en_ff    <= wr_merged[sarc_pkg::CTRL_NAP_BIT];
        pd_en_ff     <= wr_merged[sarc_pkg::CTRL_PD_BIT];
      end
      if (wr_fire && waddr_ff == sarc_pkg::OFS_RANGE)
        range_cfg_ff <= wr_merged[11:0];
      if (state_ff == sarc_pkg::ST_DONE)
        done_ff <= 1'b1;
      else if (wr_fire && waddr_ff == sarc_pkg::OFS_STATUS &&
               wstrb_ff[0] && wdata_ff[sarc_pkg::STAT_DONE_BIT])
        done_ff <= 1'b0;
      // LVDS carries a single lane
      eff_lanes_ff <= lvds_sync_ff[1] ? 2'h0 : lanes_cfg_ff;
    end
  end

  function automatic logic [31:0] sarc_merge_c();
    if (waddr_ff == sarc_pkg::OFS_CTRL)
      return sarc_pkg::sarc_merge({28'h0, pd_en_ff, nap_en_ff,
                                   lanes_cfg_ff}, wdata_ff, wstrb_ff);
    else
      return sarc_pkg::sarc_merge({20'h0, range_cfg_ff},
                                  wdata_ff, wstrb_ff);
  endfunction : sarc_merge_c

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      en_cfg[c] = sarc_pkg::sarc_range_of(range_cfg_ff, c)
                  != sarc_pkg::RANGE_OFF;
      en_cur[c] = sarc_pkg::sarc_range_of(range_cur_ff, c)
                  != sarc_pkg::RANGE_OFF;
    end
  end

  assign nxt_first = sarc_pkg::sarc_next_ch(en_cfg, 0);
  assign nxt_after = sarc_pkg::sarc_next_ch(en_cur, int'(ch_ff) + 1);

  // Conversion sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff     <= sarc_pkg::ST_TRACK;
      ch_ff        <= 2'h0;
      range_cur_ff <= sarc_pkg::RANGE_RST;
      pub_range_ff <= sarc_pkg::RANGE_RST;
      res_ff       <= '0;
      pub_ff       <= '0;
      track_ff     <= 4'hf;
      sar_start_ff <= 1'b0;
      nap_ff       <= 1'b0;
      conv_cnt_ff  <= 16'h0000;
    end else begin
      sar_start_ff <= 1'b0;
      unique case (state_ff)
        sarc_pkg::ST_TRACK: begin
          if (cnv_rise && !pd_en_ff) begin
            track_ff     <= 4'h0;
            range_cur_ff <= range_cfg_ff;
            res_ff       <= '0;
            nap_ff       <= 1'b0;
            ch_ff        <= nxt_first[1:0];
            state_ff     <= nxt_first[2] ? sarc_pkg::ST_LOAD
                                         : sarc_pkg::ST_DONE;
          end
        end
        sarc_pkg::ST_LOAD: begin
          sar_start_ff <= 1'b1;
          state_ff     <= sarc_pkg::ST_SAR;
        end
        sarc_pkg::ST_SAR: begin
          if (sar_done) begin
            res_ff[FW - 1 - int'(ch_ff)*DW -: DW] <= sarc_pkg::sarc_format(
              sar_result,
              sarc_pkg::sarc_range_of(range_cur_ff, int'(ch_ff)));
            if (nxt_after[2]) begin
              ch_ff    <= nxt_after[1:0];
              state_ff <= sarc_pkg::ST_LOAD;
            end else begin
              state_ff <= sarc_pkg::ST_DONE;
            end
          end
        end
        sarc_pkg::ST_DONE: begin
          pub_ff       <= res_ff;
          pub_range_ff <= range_cur_ff;
          track_ff     <= 4'hf;
          nap_ff       <= nap_en_ff;
          conv_cnt_ff  <= conv_cnt_ff + 16'h0001;
          state_ff     <= sarc_pkg::ST_TRACK;
        end
      endcase
    end
  end

  sarc_sar_step #(
    .SETTLE_CYCLES (SETTLE_CYCLES),
    .DATA_W        (DW)
  ) u_sar (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (sar_start_ff),
    .cmp_above (cmp_sync_ff[1]),
    .dac_code  (dac_code),
    .result    (sar_result),
    .done      (sar_done)
  );

  // Link side; cs_n high ends the frame without needing an sck edge
  always_ff @(posedge sck) begin
    lanes_s1_ff <= eff_lanes_ff;
    lanes_s2_ff <= lanes_s1_ff;
  end

  // Published words only change at conversion end, hence quasi-static
  always_comb begin
    for (int k = 0; k < NCH; k++)
      lane_words[k] = sarc_pkg::sarc_lane_word(pub_ff, k,
                                               int'(lanes_s2_ff) + 1);
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_ff <= 6'h00;
      sdo_ff     <= 4'h0;
    end else begin
      for (int k = 0; k < NCH; k++)
        sdo_ff[k] <= lane_words[k][~bit_cnt_ff];
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
    end
  end

  assign s_axi_awready     = !aw_ok_ff;
  assign s_axi_wready      = !w_ok_ff;
  assign s_axi_bvalid      = bvalid_ff;
  assign s_axi_bresp       = bresp_ff;
  assign s_axi_arready     = !rvalid_ff;
  assign s_axi_rvalid      = rvalid_ff;
  assign s_axi_rdata       = rdata_ff;
  assign s_axi_rresp       = rresp_ff;
  assign sdo               = sdo_ff;
  assign busy              = state_ff != sarc_pkg::ST_TRACK;
  assign sample_track      = track_ff;
  assign mux_channel       = ch_ff;
  assign span_code         = sarc_pkg::sarc_range_of(range_cur_ff,
                                                     int'(ch_ff));
  assign nap_active        = nap_ff;
  assign power_down_active = pd_en_ff && !busy;
  assign lvds_active       = lvds_sync_ff[1];
endmodule : sarc_top

// File: verification/sarc_top_sva.sv
/*
 Checker for sarc_top: conversion sequencing, serial idle level and
 register bus answers. Bound into sarc_top; sees its ports only,
 everything on aclk with aresetn as reset.
*/
`timescale 1ns/10ps
module sarc_top_sva #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        convert_start,
  input wire logic        cs_n,
  input wire logic [3:0]  sdo,
  input wire logic        busy,
  input wire logic [3:0]  sample_track,
  input wire logic [15:0] dac_code,
  input wire logic        power_down_active
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TRACK_IDLE: assert property (!busy |-> sample_track == 4'hf)
    else $error("channels not tracking while idle");
  AST_TRACK_SAME: assert property (sample_track inside {4'h0, 4'hf})
    else $error("channels left hold at different times");
  AST_START_BUSY: assert property ($rose(convert_start) && !busy &&
    !power_down_active |-> ##[1:6] busy)
    else $error("convert start not taken");
  AST_PD_BLOCK: assert property (power_down_active |=> !busy)
    else $error("conversion ran in power down");
  AST_DAC_MSB: assert property ($rose(busy) |-> ##[1:8] dac_code == 16'h8000)
    else $error("first trial is not half scale");
  AST_SDO_IDLE: assert property (cs_n |-> sdo == 4'h0)
    else $error("serial lanes active outside frame");
  AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");

  cover property ($fell(busy));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (power_down_active);
endmodule : sarc_top_sva

bind sarc_top sarc_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .convert_start(convert_start), .cs_n(cs_n),
  .sdo(sdo), .busy(busy), .sample_track(sample_track),
  .dac_code(dac_code), .power_down_active(power_down_active));

// File: verification/sarc_front_model.sv
/*
 Analog front end model: four sample-and-holds and one comparator.
 Assumes input levels as unsigned codes and track/hold on aclk.
*/
`timescale 1ns/10ps
module sarc_front_model (
  input wire logic        aclk,
  input wire logic [3:0]  sample_track,
  input wire logic [1:0]  mux_channel,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] lvl0,
  input wire logic [15:0] lvl1,
  input wire logic [15:0] lvl2,
  input wire logic [15:0] lvl3,
  output logic            cmp_above
);
  logic [15:0] lv      [4];
  logic [15:0] held_ff [4];

  always_comb lv = '{lvl0, lvl1, lvl2, lvl3};

  // Tracking follows input; hold freezes it, so nothing old survives
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (sample_track[i])
        held_ff[i] <= lv[i];
    end
  end

  assign cmp_above = held_ff[mux_channel] >= dac_code;
endmodule : sarc_front_model

// File: verification/sarc_top_bench.sv
/*
 Self-checking bench for sarc_top: register bus tasks, conversions
 on all range codes, serial frames on one to four lanes, power down.
 Assumes sarc_front_model as analog core; CMOS strap low until the bench raises it for the LVDS frame.
*/
`timescale 1ns/10ps
module sarc_top_bench;
  logic        aclk, aresetn, convert_start, lvds_select, sck, cs_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, sdo, sample_track;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mux_channel;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cmp_above, busy;
  logic        nap_active, power_down_active, lvds_active;
  logic [15:0] dac_code;
  logic [2:0]  span_code;
  logic [15:0] lvl [4];
  logic [63:0] rx  [4];
  logic [31:0] d;
  logic [1:0]  r;
  int          fails, n_checks, cyc;

  sarc_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .convert_start(convert_start),
    .cmp_above(cmp_above), .lvds_select(lvds_select), .sck(sck),
    .cs_n(cs_n), .sdo(sdo), .busy(busy), .sample_track(sample_track),
    .mux_channel(mux_channel), .dac_code(dac_code), .span_code(span_code),
    .nap_active(nap_active), .power_down_active(power_down_active),
    .lvds_active(lvds_active));

  sarc_front_model i_front (.aclk(aclk), .sample_track(sample_track),
    .mux_channel(mux_channel), .dac_code(dac_code), .lvl0(lvl[0]),
    .lvl1(lvl[1]), .lvl2(lvl[2]), .lvl3(lvl[3]), .cmp_above(cmp_above));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 0;
    w_ok  = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Link clock runs only inside the frame
  task automatic frame(input int nb);
    rx   = '{default: 64'h0};
    cs_n = 1'b0;
    #40;
    for (int n = 0; n < nb; n++) begin
      sck = 1'b1;
      #40;
      sck = 1'b0;
      for (int k = 0; k < 4; k++)
        rx[k] = {rx[k][62:0], sdo[k]};
      #40;
    end
    cs_n = 1'b1;
    #40;
  endtask : frame

  function automatic logic [15:0] exp_code(input logic [15:0] v,
                                           input logic [2:0]  g);
    if (g == 3'h0)
      return 16'h0;
    if (g inside {3'h7, 3'h6, 3'h3, 3'h2})
      return {~v[15], v[14:0]};
    return v;
  endfunction : exp_code

  task automatic run_case(input logic [11:0] rw, input logic nap,
                          input logic [15:0] n_conv);
    logic [63:0] ex;
    int          nb, cnt;
    axi_wr(8'h00, {29'h0, nap, 2'h0});
    axi_wr(8'h04, {20'h0, rw});
    @(posedge aclk);
    convert_start <= 1'b1;
    repeat (4) @(posedge aclk);
    convert_start <= 1'b0;
    axi_wr(8'h04, 32'h0); // Range change mid-run must not leak in
    do @(posedge aclk); while (busy !== 1'b0);
    chk(nap_active, nap);
    for (int c = 0; c < 4; c++) begin
      axi_rd(8'(16 + 4 * c));
      chk(d, {rw[3*c +: 3], exp_code(lvl[c], rw[3*c +: 3])});
    end
    axi_rd(8'h08);
    chk(d & 32'hffff0003, {n_conv, 16'h0002});
    for (int l = 1; l <= 4; l++) begin
      axi_wr(8'h00, {29'h0, nap, 2'(l - 1)});
      frame(2);
      nb = 16 * ((4 + l - 1) / l);
      frame(nb);
      for (int k = 0; k < l; k++) begin
        ex  = 64'h0;
        cnt = 0;
        for (int c = k; c < 4; c += l) begin
          ex = {ex[47:0], exp_code(lvl[c], rw[3*c +: 3])};
          cnt++;
        end
        chk(rx[k] >> (nb - 16 * cnt), ex);
      end
    end
  endtask : run_case

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, convert_start} = '0;
    s_axi_wstrb = 4'hf;
    lvds_select = 1'b0;
    sck = 1'b0;
    cs_n = 1'b0;
    lvl = '{default: 16'h0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Link bit count and sdo have no reset; a rising cs_n clears them
    cs_n    <= 1'b1;
    axi_rd(8'h04);
    chk(d, 32'h00000fff);
    chk(sample_track, 4'hf);
    chk({lvds_active, mux_channel, span_code}, 6'h07);
    axi_rd(8'h40);
    chk({r, d}, {2'h2, 32'h0});
    axi_wr(8'h10, 32'h1);
    chk(r, 2'h2);
    lvl <= '{16'h1234, 16'hfedc, 16'h8001, 16'h5555};
    run_case(12'h0ef, 1'b0, 16'h1);
    lvl <= '{16'hffff, 16'h0000, 16'h7fff, 16'h0001};
    run_case(12'h2a6, 1'b1, 16'h2);
    lvds_select <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(lvds_active, 1'b1);
    frame(2);
    frame(64);
    for (int c = 0; c < 4; c++)
      chk(rx[0][63 - 16 * c -: 16],
          exp_code(lvl[c], 3'(12'h2a6 >> 3 * c)));
    axi_wr(8'h08, 32'h2);
    axi_rd(8'h08);
    chk(d[1:0], 2'h0);
    axi_wr(8'h00, 32'h8);
    chk(power_down_active, 1'b1);
    @(posedge aclk);
    convert_start <= 1'b1;
    repeat (10) @(posedge aclk);
    convert_start <= 1'b0;
    chk(busy, 1'b0);
    axi_rd(8'h08);
    chk(d[31:16], 16'h2);
    close_out();
  end
endmodule : sarc_top_bench
